// [logic/msp_pkg.sv]
// constants shared by the pwm duty stepper design
package msp_pkg;
    // apb register offsets (byte addresses)
    localparam int MSP_ADDR_W = 8;
    localparam logic [7:0] MSP_OFF_CTRL = 8'h00;
    localparam logic [7:0] MSP_OFF_STATUS = 8'h04;
    localparam logic [7:0] MSP_OFF_PERIOD = 8'h08;
    localparam logic [7:0] MSP_OFF_WIDTH = 8'h0C;
    localparam logic [7:0] MSP_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] MSP_OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] MSP_OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] MSP_OFF_TICKS = 8'h1C;

    // control register bits
    localparam int MSP_CTRL_RUN_MASTER = 0;
    localparam int MSP_CTRL_RUN_SLAVE = 1;
    localparam int MSP_CTRL_STOP = 2;

    // status register fields
    localparam int MSP_ST_RUNNING = 0;
    localparam int MSP_ST_INDICATOR = 1;
    localparam int MSP_ST_PWM_LOW = 2;
    localparam int MSP_ST_DUTY_LSB = 4;

    // interrupt status / clear / enable layout
    localparam int MSP_IRQ_W = 2;
    localparam int MSP_IRQ_PERIOD = 0;
    localparam int MSP_IRQ_DUTY = 1;
    localparam logic [MSP_IRQ_W-1:0] MSP_IRQ_EN_RST = 2'h0;

    // timing: 2 ms period at 20 MHz
    localparam int MSP_CLK_HZ = 20_000_000;
    localparam int MSP_PERIOD_US = 2000;
    localparam int MSP_US_PER_S = 1_000_000;
    localparam int MSP_PERIOD_CYC =
        (MSP_CLK_HZ / MSP_US_PER_S) * MSP_PERIOD_US;
    // 250 periods of 2 ms give the 500 ms update step
    localparam int MSP_UPDATE_MS = 500;
    localparam int MSP_UPDATE_TICKS = (MSP_UPDATE_MS * 1000) / MSP_PERIOD_US;

    // duty sequence in percent of the period
    localparam int MSP_PCT_FULL = 100;
    localparam int MSP_DUTY_FIRST_PCT = 10;
    localparam int MSP_DUTY_STEP_PCT = 20;
    localparam logic [2:0] MSP_DUTY_LAST_IDX = 3'h4;
    localparam logic [2:0] MSP_DUTY_INIT_IDX = 3'h4;
    localparam logic [2:0] MSP_DUTY_FIRST_IDX = 3'h0;

    // pin levels
    localparam logic MSP_PWM_IDLE = 1'b1;
    localparam logic MSP_IND_RST = 1'b0;
endpackage : msp_pkg

// [logic/msp_down_counter.sv]
// loadable down counter used for master and slave channels
`timescale 1ns/1ps
module msp_down_counter #(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] loadVal,
    input wire logic dec,
    output logic [CNT_W-1:0] count,
    output logic zero
);
    // load has priority over counting
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (load) begin
            count <= loadVal;
        end else if (dec && count != '0) begin
            count <= count - 1'b1;
        end
    end

    // terminal state seen by the owner
    assign zero = (count == '0);
endmodule : msp_down_counter

// [logic/msp_pwm_top.sv]
// master/slave pwm generator with duty stepper and apb registers
//
// Behaviour
// - master free-runs; reload sets period, restarts slave
// - slave one-count: triggered, counts width, stops
// - default pwm period is 2 ms
// - output pin low while slave counts
// - width after reset gives 90% low
// - pin idles high before running
// - both run bits same write start together
// - period interrupt once every period
// - 250 periods trigger a width update
// - duty steps 10,30,50,70,90 percent
// - after 90% wrap back to 10%
// - indicator toggles on each update
`timescale 1ns/1ps
module msp_pwm_top
    import msp_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int PERIOD_CYC = MSP_PERIOD_CYC,
    parameter int UPDATE_TICKS = MSP_UPDATE_TICKS,
    parameter int TICK_W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and events
    output logic pwmOutPin,
    output logic indicatorOut,
    output logic periodIrq,
    output logic irq
);
    // width of the low phase for a duty index
    function automatic logic [CNT_W-1:0] widthFor(
        input logic [2:0] idx
    );
        int pct;
        int cyc;
        pct = MSP_DUTY_FIRST_PCT + MSP_DUTY_STEP_PCT * int'(idx);
        cyc = (PERIOD_CYC * pct) / MSP_PCT_FULL;
        return cyc[CNT_W-1:0];
    endfunction : widthFor

    localparam logic [CNT_W-1:0] PERIOD_RST = PERIOD_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] WIDTH_RST = widthFor(MSP_DUTY_INIT_IDX);
    localparam logic [TICK_W-1:0] TICK_LAST =
        TICK_W'(UPDATE_TICKS - 1);

    // software visible state
    logic running;
    logic [CNT_W-1:0] periodReg;
    logic [CNT_W-1:0] slaveWidthValue;
    logic [MSP_IRQ_W-1:0] irqStat;
    logic [MSP_IRQ_W-1:0] irqEn;

    // sequencer state
    logic [TICK_W-1:0] tickCnt;
    logic [2:0] dutyIdx;
    logic [2:0] next_dutyIdx;

    // channel counters
    logic [CNT_W-1:0] slaveCnt;
    logic masterZero;
    logic slaveZero;
    logic masterLoad;
    logic slaveLoad;
    logic [CNT_W-1:0] masterLoadVal;
    logic [CNT_W-1:0] slaveLoadVal;

    // event strobes
    logic startPulse;
    logic stopPulse;
    logic boundary;
    logic dutyUpdate;
    logic [MSP_IRQ_W-1:0] irqEvents;
    logic [MSP_IRQ_W-1:0] irqClrMask;
    logic [MSP_IRQ_W-1:0] next_irqStat;

    // bus decode
    logic apbSetup;
    logic apbAccess;
    logic wrEn;
    logic [7:0] regAddr;
    logic addrMapped;
    logic [31:0] rdMux;
    logic lowByte;

    // apb front end

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign apbSetup = psel && !penable;
    assign apbAccess = psel && penable;
    assign regAddr = paddr[MSP_ADDR_W-1:0];
    assign wrEn = apbAccess && pwrite && pready && addrMapped;
    assign lowByte = pstrb[0] || !pwrite;

    // word decode; upper address bits must be clear
    always_comb begin
        addrMapped = 1'b0;
        if (paddr[31:MSP_ADDR_W] == '0) begin
            case (regAddr)
                MSP_OFF_CTRL,
                MSP_OFF_STATUS,
                MSP_OFF_PERIOD,
                MSP_OFF_WIDTH,
                MSP_OFF_IRQ_STAT,
                MSP_OFF_IRQ_CLR,
                MSP_OFF_IRQ_EN,
                MSP_OFF_TICKS: addrMapped = 1'b1;
                default: addrMapped = 1'b0;
            endcase
        end
    end

    // unmapped address answers with an error in the access phase
    assign pslverr = apbAccess && !addrMapped;

    // read multiplexer; write-only clear reads as zero
    always_comb begin
        rdMux = '0;
        case (regAddr)
            MSP_OFF_CTRL: begin
                rdMux[MSP_CTRL_RUN_MASTER] = running;
                rdMux[MSP_CTRL_RUN_SLAVE] = running;
            end
            MSP_OFF_STATUS: begin
                rdMux[MSP_ST_RUNNING] = running;
                rdMux[MSP_ST_INDICATOR] = indicatorOut;
                rdMux[MSP_ST_PWM_LOW] = !pwmOutPin;
                rdMux[MSP_ST_DUTY_LSB +: 3] = dutyIdx;
            end
            MSP_OFF_PERIOD: rdMux[CNT_W-1:0] = periodReg;
            MSP_OFF_WIDTH: rdMux[CNT_W-1:0] = slaveWidthValue;
            MSP_OFF_IRQ_STAT: rdMux[MSP_IRQ_W-1:0] = irqStat;
            MSP_OFF_IRQ_EN: rdMux[MSP_IRQ_W-1:0] = irqEn;
            MSP_OFF_TICKS: rdMux[TICK_W-1:0] = tickCnt;
            default: rdMux = '0;
        endcase
        if (paddr[31:MSP_ADDR_W] != '0) begin
            rdMux = '0;
        end
    end

    // read data held in a flop for the access phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= '0;
        end else if (apbSetup && !pwrite) begin
            prdata <= rdMux;
        end
    end

    // control writes

    // one run bit alone is ignored so the channels never skew
    always_comb begin
        startPulse = 1'b0;
        stopPulse = 1'b0;
        if (wrEn && lowByte && regAddr == MSP_OFF_CTRL) begin
            startPulse = pwdata[MSP_CTRL_RUN_MASTER]
                && pwdata[MSP_CTRL_RUN_SLAVE]
                && !pwdata[MSP_CTRL_STOP];
            stopPulse = pwdata[MSP_CTRL_STOP];
        end
    end

    // run state; a start while running restarts both channels
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            running <= 1'b0;
        end else if (stopPulse) begin
            running <= 1'b0;
        end else if (startPulse) begin
            running <= 1'b1;
        end
    end

    // period reload register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            periodReg <= PERIOD_RST;
        end else if (wrEn && regAddr == MSP_OFF_PERIOD) begin
            periodReg <= pwdata[CNT_W-1:0];
        end
    end

    // slave width register; sequencer wins over a bus write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slaveWidthValue <= WIDTH_RST;
        end else if (dutyUpdate) begin
            slaveWidthValue <= widthFor(next_dutyIdx);
        end else if (wrEn && regAddr == MSP_OFF_WIDTH) begin
            slaveWidthValue <= pwdata[CNT_W-1:0];
        end
    end

    // master channel: interval timer

    // reload at zero gives periodReg cycles per period
    assign boundary = running && masterZero;
    assign masterLoad = startPulse || boundary || stopPulse;
    assign masterLoadVal = stopPulse ? '0 : periodReg - 1'b1;

    msp_down_counter #(
        .CNT_W(CNT_W)
    ) u_master (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(masterLoad),
        .loadVal(masterLoadVal),
        .dec(running),
        .count(),
        .zero(masterZero)
    );

    // slave channel: one-count mode

    // width sampled only at a trigger, so mid-period writes wait
    assign slaveLoad = startPulse || boundary || stopPulse;
    assign slaveLoadVal = stopPulse ? '0 : slaveWidthValue;

    msp_down_counter #(
        .CNT_W(CNT_W)
    ) u_slave (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(slaveLoad),
        .loadVal(slaveLoadVal),
        .dec(running),
        .count(slaveCnt),
        .zero(slaveZero)
    );

    // active-low pin: low while the slave counts, high otherwise
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwmOutPin <= MSP_PWM_IDLE;
        end else if (stopPulse) begin
            pwmOutPin <= MSP_PWM_IDLE;
        end else if (slaveLoad) begin
            pwmOutPin <= (slaveLoadVal == '0);
        end else if (running) begin
            pwmOutPin <= (slaveCnt <= 1);
        end
    end

    // duty sequencer

    // one update per UPDATE_TICKS period interrupts
    assign dutyUpdate = boundary && tickCnt == TICK_LAST;

    // step by 20 percent, wrapping from 90 back to 10
    always_comb begin
        if (dutyIdx >= MSP_DUTY_LAST_IDX) begin
            next_dutyIdx = MSP_DUTY_FIRST_IDX;
        end else begin
            next_dutyIdx = dutyIdx + 1'b1;
        end
    end

    // period interrupt counter, cleared on start
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt <= '0;
        end else if (startPulse || stopPulse) begin
            tickCnt <= '0;
        end else if (dutyUpdate) begin
            tickCnt <= '0;
        end else if (boundary) begin
            tickCnt <= tickCnt + 1'b1;
        end
    end

    // duty index tracks the value the sequencer loads into the width register; bus writes leave it unchanged
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dutyIdx <= MSP_DUTY_INIT_IDX;
        end else if (dutyUpdate) begin
            dutyIdx <= next_dutyIdx;
        end
    end

    // indicator lamp inverts on every update
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            indicatorOut <= MSP_IND_RST;
        end else if (dutyUpdate) begin
            indicatorOut <= !indicatorOut;
        end
    end

    // interrupts

    // one-cycle pulse at each period boundary
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            periodIrq <= 1'b0;
        end else begin
            periodIrq <= boundary;
        end
    end

    // hardware events feeding the sticky status bits
    always_comb begin
        irqEvents = '0;
        irqEvents[MSP_IRQ_PERIOD] = boundary;
        irqEvents[MSP_IRQ_DUTY] = dutyUpdate;
    end

    // write-one-to-clear mask from the clear register
    always_comb begin
        irqClrMask = '0;
        if (wrEn && regAddr == MSP_OFF_IRQ_CLR) begin
            irqClrMask = pwdata[MSP_IRQ_W-1:0];
        end
    end

    // an event in the clearing cycle is kept: set beats clear
    assign next_irqStat = (irqStat & ~irqClrMask) | irqEvents;

    // sticky status
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqStat <= '0;
        end else begin
            irqStat <= next_irqStat;
        end
    end

    // interrupt enable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqEn <= MSP_IRQ_EN_RST;
        end else if (wrEn && regAddr == MSP_OFF_IRQ_EN) begin
            irqEn <= pwdata[MSP_IRQ_W-1:0];
        end
    end

    // level output from flops only
    assign irq = |(irqStat & irqEn);
endmodule : msp_pwm_top

// [tb/msp_pwm_sva.sv]
// port-level assertions for the pwm duty stepper
`timescale 1ns/1ps
module msp_pwm_sva
    import msp_pkg::*;
#(
    parameter int PERIOD_CYC = MSP_PERIOD_CYC,
    parameter int UPDATE_TICKS = MSP_UPDATE_TICKS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwmOutPin,
    input wire logic indicatorOut,
    input wire logic periodIrq,
    input wire logic irq
);
    localparam int TENTH = PERIOD_CYC / 10;
    localparam int UPD_CYC = UPDATE_TICKS * PERIOD_CYC;
    logic startWr;
    logic started;
    logic seenIrq;
    logic seenFall;
    logic seenInd;
    logic pinQ;
    logic indQ;
    int sinceIrq;
    int sinceFall;
    int sinceInd;
    int lowCnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a start is both run bits in one write with stop clear
    assign startWr = psel && penable && pwrite && pready
        && paddr == {24'h000000, MSP_OFF_CTRL}
        && pwdata[1:0] == 2'h3 && !pwdata[2] && pstrb[0];
    // seen flags restart on each start so a restart never misfires
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            started <= 1'b0;
            seenIrq <= 1'b0;
            seenFall <= 1'b0;
            seenInd <= 1'b0;
            pinQ <= 1'b1;
            indQ <= 1'b0;
        end else begin
            started <= started || startWr;
            seenIrq <= !startWr && (seenIrq || periodIrq);
            seenFall <= !startWr && (seenFall || (pinQ && !pwmOutPin));
            seenInd <= !startWr && (seenInd || indQ != indicatorOut);
            pinQ <= pwmOutPin;
            indQ <= indicatorOut;
        end
    end
    // spacing counters between events
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sinceIrq <= 0;
            sinceFall <= 0;
            sinceInd <= 0;
            lowCnt <= 0;
        end else begin
            sinceIrq <= (periodIrq || startWr) ? 0 : sinceIrq + 1;
            sinceFall <= (pinQ && !pwmOutPin) ? 0 : sinceFall + 1;
            sinceInd <= (indQ != indicatorOut) ? 0 : sinceInd + 1;
            lowCnt <= pwmOutPin ? 0 : lowCnt + 1;
        end
    end
    a_idle_pin: assert property (!started |-> pwmOutPin)
        else $error("pin left idle level before start");
    a_start_low: assert property (startWr |-> ##[1:2] !pwmOutPin)
        else $error("pin not low after start");
    a_irq_pulse: assert property (periodIrq |=> !periodIrq [*8])
        else $error("period event not a single pulse");
    a_irq_spacing: assert property (periodIrq && seenIrq
        |-> sinceIrq == PERIOD_CYC - 1)
        else $error("period event spacing wrong");
    a_pulse_period: assert property ($fell(pwmOutPin) && seenFall
        |-> sinceFall == PERIOD_CYC - 1)
        else $error("pwm period wrong");
    a_low_width: assert property ($rose(pwmOutPin) && started
        |-> lowCnt % TENTH == 0 && (lowCnt / TENTH) inside {1, 3, 5, 7, 9})
        else $error("low width off the duty grid");
    a_ind_spacing: assert property ($changed(indicatorOut) && seenInd
        |-> sinceInd == UPD_CYC - 1)
        else $error("indicator toggle spacing wrong");
    a_unmapped_err: assert property (psel && penable && paddr[31:8] != 0
        |-> pslverr)
        else $error("unmapped access without error");
    cover property (startWr);
    cover property ($changed(indicatorOut) && seenInd);
    cover property ($rose(pwmOutPin) && started);
endmodule : msp_pwm_sva

bind msp_pwm_top msp_pwm_sva #(
    .PERIOD_CYC(PERIOD_CYC),
    .UPDATE_TICKS(UPDATE_TICKS)
) u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwmOutPin(pwmOutPin), .indicatorOut(indicatorOut),
    .periodIrq(periodIrq), .irq(irq)
);

// [tb/msp_led_model.sv]
// lamp on the active-low pwm pin, measures each lit pulse
`timescale 1ns/1ps
module msp_led_model (
    input wire logic clk_sys,
    input wire logic pwmPin,
    output int litCycles,
    output int pulses
);
    int run;
    // lamp conducts only while the pin is driven low
    always_ff @(posedge clk_sys) begin
        if (pwmPin === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            litCycles <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
endmodule : msp_led_model

// [tb/msp_pwm_top_test.sv]
// self-checking bench for the pwm duty stepper
`timescale 1ns/1ps
module msp_pwm_top_test
    import msp_pkg::*;
;
    localparam int P = 100;
    localparam int U = 4;
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [3:0] pstrb;
    logic pwmOutPin, indicatorOut, periodIrq, irq, lastErr;
    int litCycles, pulses, errTotal, comparisons;
    msp_pwm_top #(.PERIOD_CYC(P), .UPDATE_TICKS(U)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwmOutPin(pwmOutPin), .indicatorOut(indicatorOut),
        .periodIrq(periodIrq), .irq(irq));
    msp_led_model u_led (.clk_sys(clk_sys), .pwmPin(pwmOutPin),
        .litCycles(litCycles), .pulses(pulses));
    task automatic stopTest();
        if (errTotal == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stopTest
    task automatic giveUp();
        errTotal++;
        stopTest();
    endtask : giveUp
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) giveUp();
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, {24'h000000, a}, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic waitPulses(input int k);
        int goal;
        int n;
        goal = pulses + k;
        n = 0;
        while (pulses < goal && n < 2 * P * k) begin
            @(posedge clk_sys);
            n++;
        end
        if (pulses < goal) giveUp();
    endtask : waitPulses
    task automatic tReset();
        check(pwmOutPin, 1'b1);
        check(indicatorOut, 1'b0);
        rd(MSP_OFF_STATUS, 32'h40);
        rd(MSP_OFF_PERIOD, P);
        rd(MSP_OFF_WIDTH, P * 9 / 10);
        apb(1'b0, 32'h100, 32'h0);
        check(lastErr, 1'b1);
        check(q, 32'h0);
    endtask : tReset
    task automatic tRefuse();
        apb(1'b1, {24'h000000, MSP_OFF_CTRL}, 32'h1);
        repeat (3) @(posedge clk_sys);
        check(pwmOutPin, 1'b1);
        rd(MSP_OFF_STATUS, 32'h40);
    endtask : tRefuse
    // width written mid-pulse waits for the next boundary
    task automatic tStart();
        apb(1'b1, {24'h000000, MSP_OFF_IRQ_EN}, 32'h1);
        apb(1'b1, {24'h000000, MSP_OFF_CTRL}, 32'h3);
        repeat (5) @(posedge clk_sys);
        apb(1'b1, {24'h000000, MSP_OFF_WIDTH}, P * 3 / 10);
        waitPulses(1);
        check(litCycles, P * 9 / 10);
        waitPulses(1);
        check(litCycles, P * 3 / 10);
        check(irq, 1'b1);
        apb(1'b1, {24'h000000, MSP_OFF_IRQ_EN}, 32'h0);
        @(posedge clk_sys);
        check(irq, 1'b0);
        apb(1'b1, {24'h000000, MSP_OFF_IRQ_EN}, 32'h1);
        @(posedge clk_sys);
        check(irq, 1'b1);
        apb(1'b1, {24'h000000, MSP_OFF_IRQ_CLR}, 32'h1);
        @(posedge clk_sys);
        check(irq, 1'b0);
        rd(MSP_OFF_IRQ_STAT, 32'h0);
    endtask : tStart
    // five updates walk the duty grid, the sixth wraps
    task automatic tSequence();
        int pct;
        int n;
        logic old;
        for (int i = 0; i < 6; i++) begin
            pct = (i == 5) ? 10 : 10 + 20 * i;
            old = indicatorOut;
            n = 0;
            while (indicatorOut === old && n < 2 * U * P) begin
                @(posedge clk_sys);
                n++;
            end
            check(indicatorOut, !old);
            waitPulses(2);
            check(litCycles, P * pct / 100);
        end
    endtask : tSequence
    // stop silences the pin; both sticky events were raised by now
    task automatic tStop();
        int k;
        rd(MSP_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, {24'h000000, MSP_OFF_CTRL}, 32'h4);
        k = pulses;
        repeat (2 * P) @(posedge clk_sys);
        check(pulses, k);
        check(pwmOutPin, 1'b1);
        rd(MSP_OFF_STATUS, 32'h0);
    endtask : tStop
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        tReset();
        tRefuse();
        tStart();
        tSequence();
        tStop();
        stopTest();
    end
endmodule : msp_pwm_top_test
